// file: bench/uart_line_modem_control_tb.sv
// Purpose: Self-checking bench for the line and modem control block
// Assumes: Divisor at its reset value, so one bit is 16 clocks
// Notes:   Expected frames are built here from the format bits
`timescale 1ns/1ps
`default_nettype none
`include "uart_lmc_consts.vh"
module uart_line_modem_control_tb;
   localparam int BIT = 16;
   logic        i_clk_sys, i_rstn, i_psel, i_penable, i_pwrite, err;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, r;
   logic        o_pready, o_pslverr, i_sin, i_cts_n, o_sout, o_rts_n;
   int          failures, cmp_count;
   uart_line_modem_control uart_line_modem_control_i (
      .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sin(i_sin), .i_cts_n(i_cts_n),
      .o_sout(o_sout), .o_rts_n(o_rts_n));
   uart_remote_partner #(.BIT_CLKS(BIT)) uart_remote_partner_i (
      .i_clk_sys(i_clk_sys), .i_line(o_sout), .o_line(i_sin), .o_cts_n(i_cts_n));
   initial begin
      i_clk_sys = 1'b0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One idle cycle after each transfer keeps drivers to one update per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk_sys);
      end while (o_pready !== 1'b1);
      r = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(r & {24'h0, m}, {24'h0, e});
   endtask
   task automatic idle;
      do begin
         apb(1'b0, `ADR_STAT, 32'h0);
      end while (r[0] !== 1'b0);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] d);
      logic [7:0] m;
      int         n;
      n = 5 + lc[1:0];
      m = d & (8'hFF >> (3 - lc[1:0]));
      frame = 12'hFFF;
      frame[0] = 1'b0;
      for (int i = 0; i < n; i++)
         frame[i + 1] = m[i];
      if (lc[3])
         frame[n + 1] = ^m ^ ~lc[4];
   endfunction
   task automatic t_reset;
      chk(o_rts_n, 1'b1);
      rc(`ADR_LCTL, 8'hFF, 8'h00);
      rc(`ADR_MCTL, 8'hFF, 8'h00);
      apb(1'b0, 8'h20, 32'h0);
      chk({r[31:1], err}, 32'h1);
   endtask
   task automatic t_format;
      logic [7:0]  lcs [4] = '{8'h03, 8'h1C, 8'h0D, 8'h16};
      logic [11:0] b1, b2;
      int          t1, t2, e, n;
      foreach (lcs[i]) begin
         idle();
         wr(`ADR_LCTL, lcs[i]);
         n = 7 + lcs[i][1:0] + lcs[i][3];
         e = BIT * (n - 1) + (!lcs[i][2] ? BIT : lcs[i][1:0] == 2'h0 ? BIT * 3 / 2 : 2 * BIT);
         fork
            begin
               uart_remote_partner_i.get_frame(n, b1, t1);
               uart_remote_partner_i.get_frame(n, b2, t2);
            end
            begin
               wr(`ADR_DATA, 8'hA7);
               wr(`ADR_DATA, 8'h35);
            end
         join
         chk(b1, frame(lcs[i], 8'hA7));
         chk(b2, frame(lcs[i], 8'h35));
         chk(t2 - t1 >= e && t2 - t1 <= e + 3, 1'b1);
      end
   endtask
   task automatic t_busy;
      idle();
      wr(`ADR_LCTL, 8'h03);
      wr(`ADR_DATA, 8'hFF);
      wr(`ADR_LCTL, 8'h5C);
      rc(`ADR_LCTL, 8'hFF, 8'h43);
      rc(`ADR_IIDF, 8'h0F, 8'h07);
      chk(o_sout, 1'b0);
      rc(`ADR_STAT, 8'h01, 8'h01);
      rc(`ADR_IIDF, 8'h0F, 8'h01);
      idle();
      wr(`ADR_LCTL, 8'h03);
      tick(3);
      chk(o_sout, 1'b1);
   endtask
   task automatic t_div;
      wr(`ADR_IEN, 8'h0F);
      wr(`ADR_LCTL, 8'h83);
      wr(`ADR_DATA, 8'h02);
      rc(`ADR_DATA, 8'hFF, 8'h02);
      rc(`ADR_IEN, 8'hFF, 8'h00);
      wr(`ADR_DATA, 8'h01);
      wr(`ADR_LCTL, 8'h1F);
      rc(`ADR_IEN, 8'hFF, 8'h0F);
      wr(`ADR_IEN, 8'h00);
   endtask
   task automatic t_rx;
      logic [11:0] f1, f2;
      f1 = frame(8'h1F, 8'h3C);
      f2 = frame(8'h1F, 8'hC3);
      wr(`ADR_IIDF, 8'h01);
      uart_remote_partner_i.send_frame({2'h3, f2[10:0], f1[10:0]}, 22);
      tick(20);
      rc(`ADR_DATA, 8'hFF, 8'h3C);
      rc(`ADR_DATA, 8'hFF, 8'hC3);
   endtask
   task automatic t_flow;
      wr(`ADR_MCTL, 8'h02);
      tick(4);
      chk(o_rts_n, 1'b0);
      wr(`ADR_MCTL, 8'h22);
      tick(3);
      chk(o_rts_n, 1'b0);
      uart_remote_partner_i.send_frame({12'hFFF, frame(8'h1F, 8'h55)}, 11);
      tick(12);
      chk(o_rts_n, 1'b1);
      rc(`ADR_DATA, 8'hFF, 8'h55);
      tick(3);
      chk(o_rts_n, 1'b0);
      wr(`ADR_MCTL, 8'h20);
      tick(3);
      chk(o_rts_n, 1'b1);
   endtask
   task automatic t_loop;
      int k;
      k = 0;
      uart_remote_partner_i.set_cts(1'b1);
      wr(`ADR_MCTL, 8'h32);
      wr(`ADR_DATA, 8'h5A);
      wr(`ADR_LCTL, 8'h1F);
      rc(`ADR_IIDF, 8'h0F, 8'h07);
      repeat (260) begin
         @(posedge i_clk_sys);
         k += (o_sout !== 1'b1);
      end
      chk(k, 0);
      rc(`ADR_DATA, 8'hFF, 8'h5A);
      wr(`ADR_MCTL, 8'h00);
   endtask
   initial begin
      failures = 0;
      cmp_count = 0;
      i_rstn = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      tick(8);
      i_rstn <= 1'b1;
      tick(1);
      t_reset();
      t_format();
      t_busy();
      t_div();
      t_rx();
      t_flow();
      t_loop();
      test_done();
   end
   // Whole run is near 2500 cycles; eight times that means a hang
   initial begin
      tick(20000);
      chk(32'h0, 32'h1);
      test_done();
   end
endmodule // uart_line_modem_control_tb
`default_nettype wire

// file: bench/uart_lmc_checker_assertions.sv
// Purpose: Port checker for the line and modem control block
// Assumes: Control bits shadowed from completed APB writes
// Notes:   Pins judged from three cycles after the last control write
`timescale 1ns/1ps
`default_nettype none
`include "uart_lmc_consts.vh"
module uart_lmc_checker (
   input wire logic        i_clk_sys,
   input wire logic        i_rstn,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        i_sin,
   input wire logic        i_cts_n,
   input wire logic        o_sout,
   input wire logic        o_rts_n
);
   logic       wr_ok;
   logic       ctl_wr;
   logic [2:0] mc_q;
   logic       brk_q;
   logic [1:0] age_q;
   assign wr_ok = i_psel && i_penable && o_pready && i_pwrite;
   assign ctl_wr = wr_ok && (i_paddr == `ADR_MCTL || i_paddr == `ADR_LCTL);
   // Break bit is stored even while busy, so the shadow needs no busy view
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         mc_q <= 3'h0;
         brk_q <= 1'b0;
         age_q <= 2'h0;
      end else begin
         if (wr_ok && i_paddr == `ADR_MCTL)
            mc_q <= {i_pwdata[5:4], i_pwdata[1]};
         if (wr_ok && i_paddr == `ADR_LCTL)
            brk_q <= i_pwdata[6];
         if (ctl_wr)
            age_q <= 2'h0;
         else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   AST_READY_ONE_WAIT: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("ready missing after one wait state");
   AST_READY_PULSE: assert property ($rose(o_pready) |=> $fell(o_pready))
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("error without ready or with data");
   AST_READ_UPPER_ZERO: assert property (o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_BREAK_LOW: assert property (brk_q && !mc_q[1] && age_q == 2'h3 |-> !o_sout)
      else $error("serial output high during break");
   AST_LOOP_HOLD: assert property (mc_q[1] && age_q == 2'h3 |-> o_sout && o_rts_n)
      else $error("pins not held high in loopback");
   AST_RTS_ON: assert property (mc_q == 3'h1 && age_q == 2'h3 |-> !o_rts_n)
      else $error("request-to-send not asserted");
   AST_RTS_OFF: assert property (!mc_q[0] && age_q == 2'h3 |-> o_rts_n [*2])
      else $error("backpressure missing with field clear");
   cover property (brk_q && age_q == 2'h3);
   cover property (mc_q[1] && age_q == 2'h3);
   cover property (o_pslverr);
endmodule // uart_lmc_checker
bind uart_line_modem_control uart_lmc_checker uart_lmc_checker_i (
   .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sin(i_sin), .i_cts_n(i_cts_n),
   .o_sout(o_sout), .o_rts_n(o_rts_n));
`default_nettype wire

// file: bench/uart_remote_partner.sv
// Purpose: Remote serial partner: frame sender, frame sampler, clear-to-send
// Assumes: Bit time of BIT_CLKS clocks on the port clock
// Notes:   Line idles high between frames, as a pulled-up line would
`timescale 1ns/1ps
`default_nettype none
module uart_remote_partner #(
   parameter int BIT_CLKS = 16
) (
   input  wire logic i_clk_sys,
   input  wire logic i_line,
   output logic      o_line,
   output logic      o_cts_n
);
   int cyc;
   initial begin
      cyc = 0;
      o_line = 1'b1;
      o_cts_n = 1'b0;
   end
   always @(posedge i_clk_sys)
      cyc <= cyc + 1;
   // Frames are sent whole, so back-to-back characters need one call
   task automatic send_frame(input logic [23:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         o_line <= b[i];
         repeat (BIT_CLKS) @(posedge i_clk_sys);
      end
      o_line <= 1'b1;
   endtask
   // Returns at mid first stop so a following start edge is not missed
   task automatic get_frame(input int n, output logic [11:0] b, output int t0);
      int k;
      k = 0;
      b = 12'hFFF;
      while (i_line !== 1'b0 && k < 4000) begin
         @(posedge i_clk_sys);
         k++;
      end
      t0 = cyc;
      repeat (BIT_CLKS / 2) @(posedge i_clk_sys);
      for (int i = 0; i < n; i++) begin
         if (i > 0)
            repeat (BIT_CLKS) @(posedge i_clk_sys);
         b[i] = i_line;
      end
   endtask
   task automatic set_cts(input logic v);
      o_cts_n <= v;
   endtask
endmodule // uart_remote_partner
`default_nettype wire

// file: inc/uart_lmc_consts.vh
// Purpose: Offsets, field positions, reset values and timing counts of the
//          line and modem control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Definitions only
`ifndef UART_LMC_CONSTS_VH
`define UART_LMC_CONSTS_VH

`define ADR_DATA     8'h00
`define ADR_IEN      8'h04
`define ADR_IIDF     8'h08
`define ADR_LCTL     8'h0C
`define ADR_MCTL     8'h10
`define ADR_STAT     8'h14

`define LC_DIVISOR_ACCESS_BIT      7
`define LC_BRK       6
`define LC_EPS       4
`define LC_PEN       3
`define LC_STOP      2
`define LC_DLS_HI    1
`define LC_DLS_LO    0

`define MC_AUTO_FLOW_ON      5
`define MC_LOOP      4
`define MC_RTS       1

`define FC_TRIG_HI   7
`define FC_TRIG_LO   6
`define FC_TXRST     2
`define FC_RXRST     1
`define FC_FIFOE     0

`define LCTL_RST     8'h00
`define MCTL_RST     8'h00
`define IEN_RST      8'h00
`define TRIG_RST     2'h1
`define DIV_RST      16'h0001

`define IID_BUSY     4'h7
`define IID_NONE     4'h1

`define HALF_OVS     19'h00008
`define RX_DEPTH     5'h10
`define TRIG_L0      5'h01
`define TRIG_L1      5'h04
`define TRIG_L2      5'h08
`define TRIG_L3      5'h0E

`endif

// file: verilog/uart_line_modem_control.v
// Purpose: Line and modem control of an asynchronous serial port, APB slave
// Assumes: APB inputs synchronous to i_clk_sys; serial pins idle high
// Notes:   One transmit holding byte, sixteen-byte receive store
//
// Overview of operation
// R1 - Line control writes while busy change only the break bit.
// R2 - Line control reads back at any time.
// R3 - Divisor-access bit 7 maps divisor bytes onto data and enable offsets.
// R4 - Software clears divisor-access bit before normal data access.
// R5 - Break bit 6 holds serial output low unless in loopback.
// R6 - Parity enable bit 3 adds and checks parity on each character.
// R7 - Bit 4 set gives even parity, clear gives odd.
// R8 - Stop bit 2: one stop, or 1.5 for five bits, else two.
// R9 - Receiver checks only the first stop bit.
// R10 - Bits 1:0 choose five to eight data bits.
// R11 - Software enabling auto flow also enables FIFOs and request-to-send.
// R12 - Loopback bit 4 holds output high and feeds transmit to receiver.
// R13 - Interrupt sources behave the same in loopback.
// R14 - Loopback ignores external clear-to-send and uses own request-to-send.
// R15 - Request-to-send bit 1 drives the active-low output inversely.
// R16 - Auto flow may additionally force request-to-send output high.
// R17 - Request-to-send field clear means constant backpressure.
// R18 - Auto flow raises backpressure at the receive trigger level.
// R19 - Busy line control write flags busy-detect, cleared by status read.
// R20 - Parity follows last data bit; data goes least significant first.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_lmc_consts.vh"
module uart_line_modem_control (
   input  wire        i_clk_sys,
   input  wire        i_rstn,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output reg         o_pready,
   output reg         o_pslverr,
   input  wire        i_sin,
   input  wire        i_cts_n,
   output reg         o_sout,
   output reg         o_rts_n
);
   reg  [7:0]  lctl_q;
   reg  [7:0]  mctl_q;
   reg  [7:0]  ien_q;
   reg  [15:0] div_q;
   reg         fifo_en_q;
   reg  [1:0]  trig_q;
   reg  [7:0]  thr_q;
   reg         thr_full_q;
   reg         busy_det_q;
   reg  [3:0]  wp_q;
   reg  [3:0]  rp_q;
   reg  [4:0]  lvl_q;
   reg  [31:0] rdata_d;
   reg         mapped_d;
   reg  [4:0]  trig_lvl_d;

   wire        tx_line;
   wire        tx_busy;
   wire        rx_busy;
   wire        rx_done;
   wire [7:0]  rx_data;
   wire [7:0]  store_rdata;

   wire        divisor_access_bit     = lctl_q[`LC_DIVISOR_ACCESS_BIT];
   wire        loop     = mctl_q[`MC_LOOP];
   wire        auto_flow_on     = mctl_q[`MC_AUTO_FLOW_ON];
   wire        port_busy = tx_busy | rx_busy | thr_full_q;
   wire        acc      = i_psel & i_penable;
   wire        done     = acc & o_pready;
   wire        wr       = done & i_pwrite & ~o_pslverr;
   wire        rd       = done & ~i_pwrite & ~o_pslverr;
   wire        wr_data  = wr & (i_paddr == `ADR_DATA);
   wire        wr_ien   = wr & (i_paddr == `ADR_IEN);
   wire        wr_fctl  = wr & (i_paddr == `ADR_IIDF);
   wire        wr_lctl  = wr & (i_paddr == `ADR_LCTL);
   wire        wr_mctl  = wr & (i_paddr == `ADR_MCTL);
   wire        rd_data  = rd & (i_paddr == `ADR_DATA) & ~divisor_access_bit;
   wire        rd_stat  = rd & (i_paddr == `ADR_STAT);
   wire [4:0]  cap      = fifo_en_q ? `RX_DEPTH : 5'h01;
   wire        rx_flush = wr_fctl & (i_pwdata[`FC_RXRST] |
                          (i_pwdata[`FC_FIFOE] != fifo_en_q));
   wire        push     = rx_done & (lvl_q < cap) & ~rx_flush;
   wire        pop      = rd_data & (lvl_q != 5'h00) & ~rx_flush;

   // Backpressure: software field clear, or auto flow at the trigger level
   wire        bp_fill  = auto_flow_on & fifo_en_q & (lvl_q >= trig_lvl_d);  // [R18]
   wire        rts_on   = mctl_q[`MC_RTS] & ~bp_fill;                // [R16] [R17]
   wire        cts_on   = loop ? rts_on : ~i_cts_n;                  // [R14]
   wire        tx_go    = thr_full_q & ~tx_busy & (~auto_flow_on | cts_on);
   wire        line_out = lctl_q[`LC_BRK] ? 1'b0 : tx_line;
   wire        rx_in    = loop ? line_out : i_sin;                   // [R12]
   wire [18:0] half_len = {div_q, 3'h0};

   always @* begin
      case (trig_q)
         2'h0:    trig_lvl_d = `TRIG_L0;
         2'h1:    trig_lvl_d = `TRIG_L1;
         2'h2:    trig_lvl_d = `TRIG_L2;
         default: trig_lvl_d = `TRIG_L3;
      endcase
   end

   uart_serial_engine u_engine (
      .i_clk_sys  (i_clk_sys),
      .i_rstn     (i_rstn),
      .i_half_len (half_len),
      .i_tx_start (tx_go),
      .i_tx_data  (thr_q),
      .i_dls      (lctl_q[`LC_DLS_HI:`LC_DLS_LO]),
      .i_pen      (lctl_q[`LC_PEN]),
      .i_eps      (lctl_q[`LC_EPS]),
      .i_stop     (lctl_q[`LC_STOP]),
      .i_rxd      (rx_in),
      .o_tx_line  (tx_line),
      .o_tx_busy  (tx_busy),
      .o_rx_busy  (rx_busy),
      .o_rx_done  (rx_done),
      .o_rx_data  (rx_data),
      .o_rx_perr  (),
      .o_rx_ferr  ()
   );

   uart_rx_store u_store (
      .i_clk_sys (i_clk_sys),
      .i_we      (push),
      .i_waddr   (wp_q),
      .i_wdata   (rx_data),
      .i_raddr   (rp_q),
      .o_rdata   (store_rdata)
   );

   // Read mux; offsets not listed answer with an error
   always @* begin
      rdata_d  = 32'h00000000;
      mapped_d = 1'b1;
      case (i_paddr)
         `ADR_DATA: begin
            rdata_d[7:0] = divisor_access_bit ? div_q[7:0] : store_rdata;   // [R3]
         end
         `ADR_IEN: begin
            rdata_d[7:0] = divisor_access_bit ? div_q[15:8] : ien_q;        // [R3]
         end
         `ADR_IIDF: begin
            rdata_d[7:0] = {fifo_en_q, fifo_en_q, 2'h0,
                            busy_det_q ? `IID_BUSY : `IID_NONE}; // [R19]
         end
         `ADR_LCTL: begin
            rdata_d[7:0] = lctl_q;                            // [R2]
         end
         `ADR_MCTL: begin
            rdata_d[7:0] = mctl_q;
         end
         `ADR_STAT: begin
            rdata_d[0] = port_busy;
         end
         default: begin
            mapped_d = 1'b0;
         end
      endcase
   end

   // One wait state: ready rises in the second access cycle
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h00000000;
      end else begin
         o_pready  <= acc & ~o_pready;
         o_pslverr <= acc & ~o_pready & ~mapped_d;
         if (acc & ~o_pready) begin
            o_prdata <= i_pwrite ? 32'h00000000 : rdata_d;
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         lctl_q     <= `LCTL_RST;
         mctl_q     <= `MCTL_RST;
         ien_q      <= `IEN_RST;
         div_q      <= `DIV_RST;
         fifo_en_q  <= 1'b0;
         trig_q     <= `TRIG_RST;
         busy_det_q <= 1'b0;
      end else begin
         if (wr_lctl) begin
            if (port_busy) begin
               lctl_q[`LC_BRK] <= i_pwdata[`LC_BRK];          // [R1]
            end else begin
               lctl_q <= i_pwdata[7:0];                       // [R1]
            end
         end
         if (wr_mctl) begin
            mctl_q <= i_pwdata[7:0] & 8'h32;
         end
         if (wr_data & divisor_access_bit) begin
            div_q[7:0] <= i_pwdata[7:0];                      // [R3]
         end
         if (wr_ien & divisor_access_bit) begin
            div_q[15:8] <= i_pwdata[7:0];                     // [R3]
         end
         if (wr_ien & ~divisor_access_bit) begin
            ien_q <= i_pwdata[7:0] & 8'h8F;
         end
         if (wr_fctl) begin
            fifo_en_q <= i_pwdata[`FC_FIFOE];
            trig_q    <= i_pwdata[`FC_TRIG_HI:`FC_TRIG_LO];
         end
         // A new busy write wins over a status read in the same cycle;
         // loopback leaves this source untouched
         if (wr_lctl & port_busy) begin
            busy_det_q <= 1'b1;                               // [R19] [R13]
         end else if (rd_stat) begin
            busy_det_q <= 1'b0;                               // [R19]
         end
      end
   end

   // Transmit holding byte; a write while full replaces the byte
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         thr_q      <= 8'h00;
         thr_full_q <= 1'b0;
      end else begin
         if (wr_data & ~divisor_access_bit) begin
            thr_q      <= i_pwdata[7:0];
            thr_full_q <= 1'b1;
         end else if (tx_go | (wr_fctl & i_pwdata[`FC_TXRST])) begin
            thr_full_q <= 1'b0;
         end
      end
   end

   // Receive store pointers; characters beyond capacity are dropped
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wp_q  <= 4'h0;
         rp_q  <= 4'h0;
         lvl_q <= 5'h00;
      end else if (rx_flush) begin
         wp_q  <= 4'h0;
         rp_q  <= 4'h0;
         lvl_q <= 5'h00;
      end else begin
         if (push) begin
            wp_q <= wp_q + 4'h1;
         end
         if (pop) begin
            rp_q <= rp_q + 4'h1;
         end
         case ({push, pop})
            2'b10:   lvl_q <= lvl_q + 5'h01;
            2'b01:   lvl_q <= lvl_q - 5'h01;
            default: lvl_q <= lvl_q;
         endcase
      end
   end

   // Pins come from flops; loopback parks both outputs inactive high
   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sout  <= 1'b1;
         o_rts_n <= 1'b1;
      end else begin
         o_sout  <= loop ? 1'b1 : line_out;                   // [R5] [R12]
         o_rts_n <= loop ? 1'b1 : ~rts_on;                    // [R15] [R16]
      end
   end
endmodule // uart_line_modem_control
`default_nettype wire

// file: verilog/uart_rx_store.v
// Purpose: Receive character store, sixteen bytes
// Assumes: One write and one read address per cycle
// Notes:   Read data is registered, one cycle behind the address
`timescale 1ns/1ps
`default_nettype none
module uart_rx_store (
   input  wire       i_clk_sys,
   input  wire       i_we,
   input  wire [3:0] i_waddr,
   input  wire [7:0] i_wdata,
   input  wire [3:0] i_raddr,
   output reg  [7:0] o_rdata
);
   reg [7:0] mem_q [0:15];

   always @(posedge i_clk_sys) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
   end
endmodule // uart_rx_store
`default_nettype wire

// file: verilog/uart_serial_engine.v
// Purpose: Character transmitter and receiver in half-bit steps
// Assumes: Half-bit length in clocks given by the caller, at least one
// Notes:   Receiver restarts its own timing on every start edge
`timescale 1ns/1ps
`default_nettype none
module uart_serial_engine (
   input  wire        i_clk_sys,
   input  wire        i_rstn,
   input  wire [18:0] i_half_len,
   input  wire        i_tx_start,
   input  wire [7:0]  i_tx_data,
   input  wire [1:0]  i_dls,
   input  wire        i_pen,
   input  wire        i_eps,
   input  wire        i_stop,
   input  wire        i_rxd,
   output wire        o_tx_line,
   output wire        o_tx_busy,
   output wire        o_rx_busy,
   output reg         o_rx_done,
   output reg  [7:0]  o_rx_data,
   output reg         o_rx_perr,
   output reg         o_rx_ferr
);
   localparam [1:0] RX_IDLE  = 2'h0;
   localparam [1:0] RX_START = 2'h1;
   localparam [1:0] RX_BITS  = 2'h2;

   function [7:0] mask_data;
      input [7:0] d;
      input [1:0] char_length_sel;
      begin
         mask_data = d & (8'hFF >> (3'h3 - {1'b0, char_length_sel}));
      end
   endfunction

   // Even: parity equals xor of data; odd: its inverse
   function par_bit;
      input [7:0] d;
      input       parity_even_select;
      begin
         par_bit = (^d) ^ ~parity_even_select;
      end
   endfunction

   reg  [11:0] frame_q;
   reg  [4:0]  half_q;
   reg         ph_q;
   reg  [18:0] tcnt_q;
   reg  [19:0] rcnt_q;
   reg  [1:0]  rst_q;
   reg  [3:0]  idx_q;
   reg  [9:0]  sh_q;
   reg  [11:0] frame_d;
   reg  [4:0]  total_d;
   reg  [7:0]  rd_d;
   integer     i;
   wire [3:0]  nb    = {2'h0, i_dls} + 4'h5;
   wire [3:0]  last  = nb + {3'h0, i_pen};
   wire        ttick = (tcnt_q == 19'h00000);
   wire        rtick = (rcnt_q == 20'h00000);

   assign o_tx_line = frame_q[0];
   assign o_tx_busy = (half_q != 5'h00);
   assign o_rx_busy = (rst_q != RX_IDLE);

   always @* begin
      frame_d = 12'hFFE;
      for (i = 0; i < 8; i = i + 1) begin
         if (i < nb) begin
            frame_d[i + 1] = i_tx_data[i];                        // [R10] [R20]
         end
      end
      if (i_pen) begin
         frame_d[nb + 4'h1] = par_bit(mask_data(i_tx_data, i_dls), i_eps); // [R6] [R7] [R20]
      end
      total_d = {nb, 1'b0} + {3'h0, i_pen, 1'b0} + 5'h02;
      if (!i_stop) begin
         total_d = total_d + 5'h02;                               // [R8]
      end else if (i_dls == 2'h0) begin
         total_d = total_d + 5'h03;                               // [R8]
      end else begin
         total_d = total_d + 5'h04;                               // [R8]
      end
      rd_d = mask_data(sh_q[7:0], i_dls);
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         frame_q <= 12'hFFF;
         half_q  <= 5'h00;
         ph_q    <= 1'b0;
         tcnt_q  <= 19'h00000;
      end else if (!o_tx_busy) begin
         tcnt_q <= i_half_len - 19'h00001;
         ph_q   <= 1'b0;
         if (i_tx_start) begin
            frame_q <= frame_d;
            half_q  <= total_d;
         end
      end else begin
         tcnt_q <= ttick ? i_half_len - 19'h00001 : tcnt_q - 19'h00001;
         if (ttick) begin
            half_q <= half_q - 5'h01;
            ph_q   <= ~ph_q;
            if (ph_q) begin
               frame_q <= {1'b1, frame_q[11:1]};
            end
         end
      end
   end

   always @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_q     <= RX_IDLE;
         rcnt_q    <= 19'h00000;
         idx_q     <= 4'h0;
         sh_q      <= 10'h000;
         o_rx_done <= 1'b0;
         o_rx_data <= 8'h00;
         o_rx_perr <= 1'b0;
         o_rx_ferr <= 1'b0;
      end else begin
         o_rx_done <= 1'b0;
         rcnt_q    <= rtick ? {1'b0, i_half_len} - 20'h00001 : rcnt_q - 20'h00001;
         case (rst_q)
            RX_IDLE: begin
               rcnt_q <= {1'b0, i_half_len} - 20'h00001;
               idx_q  <= 4'h0;
               if (!i_rxd) begin
                  rst_q <= RX_START;
               end
            end
            RX_START: begin
               if (rtick) begin
                  rst_q  <= i_rxd ? RX_IDLE : RX_BITS;
                  rcnt_q <= {i_half_len, 1'b0} - 20'h00001;
               end
            end
            RX_BITS: begin
               if (rtick) begin
                  rcnt_q <= {i_half_len, 1'b0} - 20'h00001;
                  if (idx_q == last) begin
                     // Only the first stop bit is looked at
                     rst_q     <= RX_IDLE;                        // [R9]
                     o_rx_done <= 1'b1;
                     o_rx_data <= rd_d;                           // [R10]
                     o_rx_ferr <= ~i_rxd;                         // [R9]
                     o_rx_perr <= i_pen & (sh_q[nb] != par_bit(rd_d, i_eps)); // [R6] [R7]
                  end else begin
                     sh_q[idx_q] <= i_rxd;
                     idx_q       <= idx_q + 4'h1;
                  end
               end
            end
            default: begin
               rst_q <= RX_IDLE;
            end
         endcase
      end
   end
endmodule // uart_serial_engine
`default_nettype wire
